// [verilog/spi_mc_defs.svh]
// Constants for the multichannel serial master: layout, widths, timing
`ifndef SPI_MC_DEFS_SVH
`define SPI_MC_DEFS_SVH
`define FIFO_STAGES 8
`define RAM_BASE 16'h1000
`define RX_AREA_OFS 16'h0020
`define RAM_AW 7
`define RAM_WORDS 128
`define FLEN_W 6
`define FCNT_W 8
`define CHANNEL_PRIORITY_W 3
`define OFS_W 16
`define BAUD_MBPS 10
`define LINK_PERIOD_PS 15000
// Half serial clock period in link cycles, rounded up so baud never exceeds
`define SCK_HALF_CYC ((1000000 + (`LINK_PERIOD_PS * `BAUD_MBPS * 2) - 1) / \
  (`LINK_PERIOD_PS * `BAUD_MBPS * 2))
`endif

// [verilog/spi_mc_pkg.sv]
// Types shared by the multichannel serial master files
package spi_mc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_HOLD = 4'b1000
  } eng_state_t;
  typedef logic [31:0] word_t;
endpackage

// [verilog/spi_link_if.sv]
// Frame handshake between the scheduler domain and the link shift domain
`timescale 1ns/1ps
`include "spi_mc_defs.svh"
interface spi_link_if #(parameter int CHW = 1);
  logic req_tgl;
  spi_mc_pkg::word_t req_word;
  logic [`FLEN_W-1:0] req_len;
  logic req_phase;
  logic req_dir;
  logic req_tx_en;
  logic [CHW-1:0] req_ch;
  logic done_tgl;
  spi_mc_pkg::word_t rx_word;
  modport sched (output req_tgl, req_word, req_len, req_phase, req_dir,
    req_tx_en, req_ch, input done_tgl, rx_word);
  modport engine (input req_tgl, req_word, req_len, req_phase, req_dir,
    req_tx_en, req_ch, output done_tgl, rx_word);
endinterface

// [verilog/spi_shift_engine.sv]
// Link-clock shift engine: serial clock, select and one frame at a time
`timescale 1ns/1ps
`include "spi_mc_defs.svh"
module spi_shift_engine #(
  parameter int NUM_CH = 2,
  parameter int CHW = 1,
  parameter int HALF_DIV = `SCK_HALF_CYC
) (
  // Link clock and scheduler-domain reset
  input wire logic i_link_clk,
  input wire logic i_rst_b,
  // Frame handshake
  spi_link_if.engine lk,
  // Serial pins
  input wire logic i_serial_data_in,
  output logic o_serial_shift_clock,
  output logic o_serial_data_out,
  output logic [NUM_CH-1:0] o_master_select_out_b
);
  spi_mc_pkg::eng_state_t state, next_state;
  logic rst_s1, rst_s2, req_s1, req_s2, sdi_s1, sdi_s2;
  logic req_seen, next_req_seen, sck, next_sck, sdo, next_sdo;
  logic done_tgl, next_done_tgl;
  logic [NUM_CH-1:0] cs_b, next_cs_b;
  logic [7:0] div, next_div;
  logic [6:0] edges, next_edges, n;
  logic [5:0] bitcnt, next_bitcnt;
  logic [4:0] bpos, fpos;
  spi_mc_pkg::word_t rx_word, next_rx_word;

  // Synchronisers; reset crosses in too, so link logic leaves reset cleanly
  always_ff @(posedge i_link_clk)
  begin
    rst_s1 <= i_rst_b;
    rst_s2 <= rst_s1;
    sdi_s1 <= i_serial_data_in;
    sdi_s2 <= sdi_s1;
    if (!rst_s2)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end
    else
    begin
      req_s1 <= lk.req_tgl;
      req_s2 <= req_s1;
    end
  end

  // Request fields are stable from the toggle until done is returned
  always_comb
  begin
    n = edges + 7'h01;
    fpos = lk.req_dir ? 5'h00 : 5'(lk.req_len - 6'h01);
    bpos = lk.req_dir ? bitcnt[4:0] : 5'(lk.req_len - 6'h01 - bitcnt);
    next_state = state;
    next_req_seen = req_seen;
    next_sck = sck;
    next_sdo = sdo;
    next_done_tgl = done_tgl;
    next_cs_b = cs_b;
    next_div = div;
    next_edges = edges;
    next_bitcnt = bitcnt;
    next_rx_word = rx_word;
    unique case (state)
      spi_mc_pkg::ST_IDLE:
      begin
        if (req_s2 != req_seen)
        begin
          next_req_seen = req_s2;
          next_cs_b[lk.req_ch] = 1'b0;
          next_div = 8'h00;
          next_edges = 7'h00;
          next_bitcnt = 6'h00;
          next_rx_word = 32'h0000_0000;
          next_state = spi_mc_pkg::ST_SETUP;
          // Phase 0 presents the first bit before the first edge
          if (!lk.req_phase)
          begin
            next_sdo = lk.req_tx_en & lk.req_word[fpos];
          end
        end
      end
      spi_mc_pkg::ST_SETUP:
      begin
        if (div == 8'(HALF_DIV - 1))
        begin
          next_div = 8'h00;
          next_state = spi_mc_pkg::ST_SHIFT;
        end
        else
        begin
          next_div = div + 8'h01;
        end
      end
      spi_mc_pkg::ST_SHIFT:
      begin
        if (div == 8'(HALF_DIV - 1))
        begin
          next_div = 8'h00;
          next_sck = ~sck;
          next_edges = n;
          if (n[0] == lk.req_phase)
          begin
            if (bitcnt < lk.req_len)
            begin
              next_sdo = lk.req_tx_en & lk.req_word[bpos];
            end
          end
          else
          begin
            next_rx_word[bpos] = sdi_s2;
            next_bitcnt = bitcnt + 6'h01;
          end
          if (n == {lk.req_len, 1'b0})
          begin
            next_state = spi_mc_pkg::ST_HOLD;
          end
        end
        else
        begin
          next_div = div + 8'h01;
        end
      end
      spi_mc_pkg::ST_HOLD:
      begin
        if (div == 8'(HALF_DIV - 1))
        begin
          next_div = 8'h00;
          next_cs_b = '1; // Select returns inactive after every frame
          next_done_tgl = ~done_tgl;
          next_state = spi_mc_pkg::ST_IDLE;
        end
        else
        begin
          next_div = div + 8'h01;
        end
      end
    endcase
  end

  // Link state registers
  always_ff @(posedge i_link_clk)
  begin
    if (!rst_s2)
    begin
      state <= spi_mc_pkg::ST_IDLE;
      req_seen <= 1'b0;
      sck <= 1'b0;
      sdo <= 1'b0;
      done_tgl <= 1'b0;
      cs_b <= '1;
      div <= 8'h00;
      edges <= 7'h00;
      bitcnt <= 6'h00;
      rx_word <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      req_seen <= next_req_seen;
      sck <= next_sck;
      sdo <= next_sdo;
      done_tgl <= next_done_tgl;
      cs_b <= next_cs_b;
      div <= next_div;
      edges <= next_edges;
      bitcnt <= next_bitcnt;
      rx_word <= next_rx_word;
    end
  end

  assign lk.done_tgl = done_tgl;
  assign lk.rx_word = rx_word;
  assign o_serial_shift_clock = sck;
  assign o_serial_data_out = sdo;
  assign o_master_select_out_b = cs_b;
endmodule // spi_shift_engine

// [verilog/spi_mc_master.sv]
// Multichannel serial master: priority scheduler, FIFO RAM and flags
`timescale 1ns/1ps
`include "spi_mc_defs.svh"
module spi_mc_master #(
  parameter int NUM_CH = 2,
  parameter int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  // Per-channel configuration
  input wire logic [NUM_CH-1:0] i_tx_enable,
  input wire logic [NUM_CH-1:0] i_rx_enable,
  input wire logic [NUM_CH-1:0] i_hw_trigger_select,
  input wire logic [NUM_CH-1:0] i_clock_phase,
  input wire logic [NUM_CH-1:0] i_lsb_first,
  input wire logic [NUM_CH-1:0][`CHANNEL_PRIORITY_W-1:0] i_channel_priority,
  input wire logic [NUM_CH-1:0][`FLEN_W-1:0] i_frame_length,
  input wire logic [NUM_CH-1:0][`FCNT_W-1:0] i_frame_count,
  input wire logic [NUM_CH-1:0][`OFS_W-1:0] i_ram_start_offset,
  // Transmit data register write and receive data register read
  input wire logic i_tx_wr,
  input wire logic [CHW-1:0] i_tx_ch,
  input wire logic [31:0] i_tx_data,
  input wire logic i_rx_rd,
  input wire logic [CHW-1:0] i_rx_ch,
  output logic [31:0] o_rx_data,
  output logic o_rx_valid,
  // Event pulses, sticky flags and their clears
  output logic [NUM_CH-1:0] o_tx_request_irq,
  output logic [NUM_CH-1:0] o_rx_ready_irq,
  output logic [NUM_CH-1:0] o_frame_end_irq,
  output logic [NUM_CH-1:0] o_irq_flag_tx,
  output logic [NUM_CH-1:0] o_irq_flag_rx,
  output logic [NUM_CH-1:0] o_irq_flag_fe,
  input wire logic [NUM_CH-1:0] i_flag_clr_tx,
  input wire logic [NUM_CH-1:0] i_flag_clr_rx,
  input wire logic [NUM_CH-1:0] i_flag_clr_fe,
  output logic [NUM_CH-1:0] o_channel_active,
  // Pins
  input wire logic i_ext_irq_pin_zero,
  input wire logic i_serial_data_in,
  output logic o_serial_shift_clock,
  output logic o_serial_data_out,
  output logic [NUM_CH-1:0] o_master_select_out_b
);
  typedef logic [NUM_CH-1:0][`FCNT_W-1:0] cnt_arr_t;

  spi_link_if #(.CHW(CHW)) lk ();

  logic [NUM_CH-1:0] chen, next_chen, rdy;
  logic [NUM_CH-1:0] flag_tx, next_flag_tx, flag_rx, next_flag_rx;
  logic [NUM_CH-1:0] flag_fe, next_flag_fe;
  logic [NUM_CH-1:0] irq_tx, next_irq_tx, irq_rx, next_irq_rx;
  logic [NUM_CH-1:0] irq_fe, next_irq_fe;
  cnt_arr_t wr_cnt, next_wr_cnt, sent_cnt, next_sent_cnt;
  cnt_arr_t recv_cnt, next_recv_cnt, rd_cnt, next_rd_cnt;
  logic busy, next_busy, req_tgl, next_req_tgl;
  logic req_phase, next_req_phase, req_dir, next_req_dir;
  logic req_tx_en, next_req_tx_en, rx_valid, next_rx_valid;
  logic [CHW-1:0] cur_ch, next_cur_ch, sel;
  logic [`FLEN_W-1:0] req_len, next_req_len;
  spi_mc_pkg::word_t req_word, next_req_word, rx_data, next_rx_data;
  logic done_s1, done_s2, done_s3, trig_s1, trig_s2, trig_s3;
  logic done_evt, trig_rise, tx_we, rx_we;
  logic [`RAM_AW-1:0] tx_wa, rx_wa;
  spi_mc_pkg::word_t ram [`RAM_WORDS];

  // Word index of a FIFO stage inside a channel's area of transfer RAM
  function automatic logic [`RAM_AW-1:0] word_addr(
    input logic [`OFS_W-1:0] ofs, input logic rx,
    input logic [`FCNT_W-1:0] cnt);
    logic [`OFS_W-1:0] a;
    a = (ofs >> 2) + (rx ? (`RX_AREA_OFS >> 2) : 16'h0000)
      + 16'(cnt % `FIFO_STAGES);
    return a[`RAM_AW-1:0];
  endfunction

  // Lowest priority value wins; ties go to the lower channel number
  function automatic logic [CHW-1:0] pick(input logic [NUM_CH-1:0] r,
    input logic [NUM_CH-1:0][`CHANNEL_PRIORITY_W-1:0] pr);
    logic [CHW-1:0] best;
    logic [`CHANNEL_PRIORITY_W:0] bp;
    best = '0;
    bp = '1;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (r[i] && ({1'b0, pr[i]} < bp))
      begin
        best = CHW'(i);
        bp = {1'b0, pr[i]};
      end
    end
    return best;
  endfunction

  // Pin and cross-domain synchronisers; only stages two and three feed logic
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      {done_s1, done_s2, done_s3} <= 3'h0;
      {trig_s1, trig_s2, trig_s3} <= 3'h0;
    end
    else
    begin
      {done_s3, done_s2, done_s1} <= {done_s2, done_s1, lk.done_tgl};
      trig_s1 <= i_ext_irq_pin_zero;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  assign done_evt = done_s2 ^ done_s3;
  assign trig_rise = trig_s2 & ~trig_s3;

  // A channel may take the port when data and receive room are there
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      rdy[c] = chen[c] && (sent_cnt[c] < i_frame_count[c])
        && (!i_tx_enable[c] || (wr_cnt[c] != sent_cnt[c]))
        && (!i_rx_enable[c] ||
            (8'(sent_cnt[c] - rd_cnt[c]) < 8'(`FIFO_STAGES)));
    end
  end
  assign sel = pick(rdy, i_channel_priority);

  // Scheduler, FIFO counters and flags
  always_comb
  begin
    next_chen = chen;
    next_wr_cnt = wr_cnt;
    next_sent_cnt = sent_cnt;
    next_recv_cnt = recv_cnt;
    next_rd_cnt = rd_cnt;
    next_busy = busy;
    next_cur_ch = cur_ch;
    next_req_tgl = req_tgl;
    next_req_word = req_word;
    next_req_len = req_len;
    next_req_phase = req_phase;
    next_req_dir = req_dir;
    next_req_tx_en = req_tx_en;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_irq_tx = '0;
    next_irq_rx = '0;
    next_irq_fe = '0;
    tx_we = 1'b0;
    tx_wa = '0;
    rx_we = 1'b0;
    rx_wa = '0;
    // Arbitration only happens while no frame is out: whole frames only
    if (done_evt)
    begin
      next_busy = 1'b0;
      if (i_rx_enable[cur_ch])
      begin
        rx_we = 1'b1;
        rx_wa = word_addr(i_ram_start_offset[cur_ch], 1'b1,
          recv_cnt[cur_ch]);
        next_irq_rx[cur_ch] = 1'b1;
      end
      next_recv_cnt[cur_ch] = recv_cnt[cur_ch] + 8'h01;
      if (next_recv_cnt[cur_ch] == i_frame_count[cur_ch])
      begin
        next_chen[cur_ch] = 1'b0;
        next_irq_fe[cur_ch] = 1'b1;
        next_wr_cnt[cur_ch] = '0;
        next_sent_cnt[cur_ch] = '0;
      end
    end
    else if (!busy && (|rdy))
    begin
      // Re-picked every frame, so a waiting channel resumes by itself
      next_busy = 1'b1;
      next_cur_ch = sel;
      next_req_tgl = ~req_tgl;
      next_req_word = i_tx_enable[sel] ?
        ram[word_addr(i_ram_start_offset[sel], 1'b0, sent_cnt[sel])] :
        32'h0000_0000;
      next_req_len = i_frame_length[sel];
      next_req_phase = i_clock_phase[sel];
      next_req_dir = i_lsb_first[sel];
      next_req_tx_en = i_tx_enable[sel];
      next_sent_cnt[sel] = sent_cnt[sel] + 8'h01;
      if (i_tx_enable[sel] && (wr_cnt[sel] < i_frame_count[sel]))
      begin
        next_irq_tx[sel] = 1'b1;
      end
    end
    // Receive read; stored count only, so a word still being written is
    // never read early; empty or receive-off reads are ignored
    if (i_rx_rd && i_rx_enable[i_rx_ch]
        && (rd_cnt[i_rx_ch] != recv_cnt[i_rx_ch]))
    begin
      next_rx_data = ram[word_addr(i_ram_start_offset[i_rx_ch], 1'b1,
        rd_cnt[i_rx_ch])];
      next_rx_valid = 1'b1;
      next_rd_cnt[i_rx_ch] = rd_cnt[i_rx_ch] + 8'h01;
    end
    // Transmit data register write; refused when the FIFO is full
    if (i_tx_wr)
    begin
      if (!next_chen[i_tx_ch] && !i_hw_trigger_select[i_tx_ch]
          && (i_frame_count[i_tx_ch] != 8'h00))
      begin
        next_chen[i_tx_ch] = 1'b1;
        next_wr_cnt[i_tx_ch] = '0;
        next_sent_cnt[i_tx_ch] = '0;
        next_recv_cnt[i_tx_ch] = '0;
        next_rd_cnt[i_tx_ch] = '0;
      end
      if ((next_chen[i_tx_ch] || i_hw_trigger_select[i_tx_ch])
          && (next_wr_cnt[i_tx_ch] < i_frame_count[i_tx_ch])
          && (8'(next_wr_cnt[i_tx_ch] - next_sent_cnt[i_tx_ch])
              < 8'(`FIFO_STAGES)))
      begin
        tx_we = 1'b1;
        tx_wa = word_addr(i_ram_start_offset[i_tx_ch], 1'b0,
          next_wr_cnt[i_tx_ch]);
        next_wr_cnt[i_tx_ch] = next_wr_cnt[i_tx_ch] + 8'h01;
      end
    end
    // Pin trigger starts idle hardware-triggered channels
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (trig_rise && i_hw_trigger_select[c] && !next_chen[c]
          && (i_frame_count[c] != 8'h00))
      begin
        next_chen[c] = 1'b1;
        next_sent_cnt[c] = '0;
        next_recv_cnt[c] = '0;
        next_rd_cnt[c] = '0;
      end
    end
    // Sticky flags: a new event in the clear cycle still sets the flag
    next_flag_tx = (flag_tx & ~i_flag_clr_tx) | next_irq_tx;
    next_flag_rx = (flag_rx & ~i_flag_clr_rx) | next_irq_rx;
    next_flag_fe = (flag_fe & ~i_flag_clr_fe) | next_irq_fe;
  end

  // Scheduler registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      chen <= '0;
      wr_cnt <= '0;
      sent_cnt <= '0;
      recv_cnt <= '0;
      rd_cnt <= '0;
      busy <= 1'b0;
      cur_ch <= '0;
      req_tgl <= 1'b0;
      req_word <= 32'h0000_0000;
      req_len <= 6'h00;
      req_phase <= 1'b0;
      req_dir <= 1'b0;
      req_tx_en <= 1'b0;
      rx_data <= 32'h0000_0000;
      rx_valid <= 1'b0;
      {irq_tx, irq_rx, irq_fe} <= '0;
      {flag_tx, flag_rx, flag_fe} <= '0;
    end
    else
    begin
      chen <= next_chen;
      wr_cnt <= next_wr_cnt;
      sent_cnt <= next_sent_cnt;
      recv_cnt <= next_recv_cnt;
      rd_cnt <= next_rd_cnt;
      busy <= next_busy;
      cur_ch <= next_cur_ch;
      req_tgl <= next_req_tgl;
      req_word <= next_req_word;
      req_len <= next_req_len;
      req_phase <= next_req_phase;
      req_dir <= next_req_dir;
      req_tx_en <= next_req_tx_en;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      {irq_tx, irq_rx, irq_fe} <= {next_irq_tx, next_irq_rx, next_irq_fe};
      {flag_tx, flag_rx, flag_fe} <=
        {next_flag_tx, next_flag_rx, next_flag_fe};
    end
  end

  // Transfer RAM; transmit and receive stages never share a word
  always_ff @(posedge i_clk)
  begin
    if (tx_we)
    begin
      ram[tx_wa] <= i_tx_data;
    end
    if (rx_we)
    begin
      ram[rx_wa] <= lk.rx_word;
    end
  end

  // Request fields held stable until the engine answers
  assign lk.req_tgl = req_tgl;
  assign lk.req_word = req_word;
  assign lk.req_len = req_len;
  assign lk.req_phase = req_phase;
  assign lk.req_dir = req_dir;
  assign lk.req_tx_en = req_tx_en;
  assign lk.req_ch = cur_ch;

  spi_shift_engine #(.NUM_CH(NUM_CH), .CHW(CHW)) u_engine (
    .i_link_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .lk(lk),
    .i_serial_data_in(i_serial_data_in),
    .o_serial_shift_clock(o_serial_shift_clock),
    .o_serial_data_out(o_serial_data_out),
    .o_master_select_out_b(o_master_select_out_b)
  );

  assign o_rx_data = rx_data;
  assign o_rx_valid = rx_valid;
  assign o_tx_request_irq = irq_tx;
  assign o_rx_ready_irq = irq_rx;
  assign o_frame_end_irq = irq_fe;
  assign o_irq_flag_tx = flag_tx;
  assign o_irq_flag_rx = flag_rx;
  assign o_irq_flag_fe = flag_fe;
  assign o_channel_active = chen;
endmodule // spi_mc_master

// [sim/spi_slave_model.sv]
// Behavioural slave: echoes the frame it last received
`timescale 1ns/1ps
module spi_slave_model #(
  parameter logic [31:0] SEED = 32'h0
) (
  // Serial side
  input wire logic i_sck,
  input wire logic i_sel_b,
  input wire logic i_mosi,
  output logic o_miso,
  // Observation
  output logic [31:0] o_last_rx,
  output int o_frames
);
  logic [31:0] tx_sh;
  logic [31:0] rx_sh;
  int nbits;
  initial
  begin
    o_miso = 1'b0;
    o_last_rx = SEED;
    o_frames = 0;
    tx_sh = SEED;
    rx_sh = '0;
    nbits = 0;
  end
  // Load echo on select; when released the output flips to the inverse of its stale level
  always @(i_sel_b)
    if (i_sel_b === 1'b0)
    begin
      tx_sh = o_last_rx;
      nbits = 0;
    end
    else
      o_miso = ~o_miso;
  // Odd edges shift out, most significant bit first
  always @(posedge i_sck)
    if (!i_sel_b)
    begin
      o_miso = tx_sh[31];
      tx_sh = tx_sh << 1;
    end
  // Even edges sample; a frame counts only when whole
  always @(negedge i_sck)
    if (!i_sel_b)
    begin
      rx_sh = {rx_sh[30:0], i_mosi};
      nbits++;
      if (nbits == 32)
      begin
        o_last_rx = rx_sh;
        o_frames++;
      end
    end
endmodule // spi_slave_model

// [sim/spi_mc_chk.sv]
// Port checker for the multichannel serial master
`timescale 1ns/1ps
`include "spi_mc_defs.svh"
module spi_mc_chk #(
  parameter int NUM_CH = 2,
  parameter int CHW = 1
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  // Watched inputs
  input wire logic [NUM_CH-1:0] i_rx_enable,
  input wire logic [NUM_CH-1:0] i_hw_trigger_select,
  input wire logic [NUM_CH-1:0][`FCNT_W-1:0] i_frame_count,
  input wire logic i_tx_wr,
  input wire logic [CHW-1:0] i_tx_ch,
  input wire logic i_rx_rd,
  input wire logic i_ext_irq_pin_zero,
  // Watched outputs
  input wire logic o_rx_valid,
  input wire logic [NUM_CH-1:0] o_rx_ready_irq,
  input wire logic [NUM_CH-1:0] o_frame_end_irq,
  input wire logic [NUM_CH-1:0] o_irq_flag_fe,
  input wire logic [NUM_CH-1:0] o_channel_active,
  input wire logic o_serial_shift_clock,
  input wire logic [NUM_CH-1:0] o_master_select_out_b
);
  // Link side: clock only under a select, selects exclusive
  property p_sck_sel;
    @(posedge i_link_clk) disable iff (!i_rst_b)
      o_serial_shift_clock |-> !(&o_master_select_out_b);
  endproperty
  a_sck_sel: assert property (p_sck_sel)
    else $error("serial clock active with no select");
  property p_sel_one;
    @(posedge i_link_clk) disable iff (!i_rst_b)
      $countones(~o_master_select_out_b) <= 1;
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("two selects low at once");
  property p_sck_half;
    @(posedge i_link_clk) disable iff (!i_rst_b)
      $rose(o_serial_shift_clock) |->
        o_serial_shift_clock[*4] ##1 !o_serial_shift_clock;
  endproperty
  a_sck_half: assert property (p_sck_half)
    else $error("serial clock high phase wrong");
  // System side: starts, completion and flags
  property p_sw_start;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_tx_wr && i_tx_ch == '0 && !i_hw_trigger_select[0] &&
      !o_channel_active[0] && i_frame_count[0] != '0 |=> o_channel_active[0];
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("write did not start channel");
  property p_hw_start;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(i_ext_irq_pin_zero) && i_hw_trigger_select[1] &&
      !o_channel_active[1] && i_frame_count[1] != '0
      |-> ##[1:6] o_channel_active[1];
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("pin did not start channel");
  property p_fe_done;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_frame_end_irq[0] |-> $fell(o_channel_active[0]);
  endproperty
  a_fe_done: assert property (p_fe_done)
    else $error("frame end without completion");
  property p_fe_flag;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_frame_end_irq != '0 |-> (o_frame_end_irq & ~o_irq_flag_fe) == '0;
  endproperty
  a_fe_flag: assert property (p_fe_flag)
    else $error("frame end flag not set");
  property p_rx_en;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_rx_ready_irq != '0 |-> (o_rx_ready_irq & ~i_rx_enable) == '0;
  endproperty
  a_rx_en: assert property (p_rx_en)
    else $error("receive event with receive off");
  property p_rd_valid;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_rx_valid |-> $past(i_rx_rd) || $past(i_rx_rd, 2);
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read data without a read");
  // Main scenarios reached
  c_preempt: cover property (@(posedge i_clk)
    o_frame_end_irq[1] && o_channel_active[0]);
  c_fe0: cover property (@(posedge i_clk) o_frame_end_irq[0]);
  c_rd: cover property (@(posedge i_clk) o_rx_valid);
endmodule // spi_mc_chk
bind spi_mc_master spi_mc_chk #(.NUM_CH(NUM_CH), .CHW(CHW)) u_chk (
  .i_clk, .i_rst_b, .i_link_clk, .i_rx_enable, .i_hw_trigger_select,
  .i_frame_count, .i_tx_wr, .i_tx_ch, .i_rx_rd, .i_ext_irq_pin_zero,
  .o_rx_valid, .o_rx_ready_irq, .o_frame_end_irq, .o_irq_flag_fe,
  .o_channel_active, .o_serial_shift_clock, .o_master_select_out_b);

// [sim/test_multichannel_spi_priority_preempt.sv]
// Self-checking bench for the multichannel serial master
`timescale 1ns/1ps
`include "spi_mc_defs.svh"
module test_multichannel_spi_priority_preempt;
  typedef struct {logic ch; int n; logic tx, rx, lsb; int ntx;} row_t;
  logic i_clk, i_rst_b, i_link_clk, i_tx_wr, i_rx_rd, i_tx_ch, i_rx_ch;
  logic [1:0] i_tx_enable, i_rx_enable, i_hw_trigger_select, i_clock_phase;
  logic [1:0] i_lsb_first, i_flag_clr_tx, i_flag_clr_rx, i_flag_clr_fe;
  logic [1:0][`CHANNEL_PRIORITY_W-1:0] i_channel_priority;
  logic [1:0][`FLEN_W-1:0] i_frame_length;
  logic [1:0][`FCNT_W-1:0] i_frame_count;
  logic [1:0][`OFS_W-1:0] i_ram_start_offset;
  logic [31:0] i_tx_data, o_rx_data, s_rx0, s_rx1;
  logic [1:0] o_tx_request_irq, o_rx_ready_irq, o_frame_end_irq;
  logic [1:0] o_irq_flag_tx, o_irq_flag_rx, o_irq_flag_fe;
  logic [1:0] o_channel_active, o_master_select_out_b;
  logic o_rx_valid, i_ext_irq_pin_zero, i_serial_data_in, s_miso0, s_miso1;
  logic o_serial_shift_clock, o_serial_data_out;
  logic [31:0] prev [2] = '{32'h8e3c71a5, 32'h1d4b9f62};
  int s_fr0, s_fr1, n_errors = 0, n_compared = 0, cyc = 0, f0, f1, t;
  row_t rows [5] = '{'{0, 8, 1, 1, 0, 7}, '{1, 3, 1, 1, 0, 2},
    '{0, 1, 1, 1, 1, 0}, '{0, 2, 0, 1, 0, 0}, '{1, 2, 1, 0, 0, 1}};
  spi_mc_master #(.NUM_CH(2), .CHW(1)) dut (.*);
  spi_slave_model #(.SEED(32'h8e3c71a5)) u_slv0 (.i_sck(o_serial_shift_clock),
    .i_sel_b(o_master_select_out_b[0]), .i_mosi(o_serial_data_out),
    .o_miso(s_miso0), .o_last_rx(s_rx0), .o_frames(s_fr0));
  spi_slave_model #(.SEED(32'h1d4b9f62)) u_slv1 (.i_sck(o_serial_shift_clock),
    .i_sel_b(o_master_select_out_b[1]), .i_mosi(o_serial_data_out),
    .o_miso(s_miso1), .o_last_rx(s_rx1), .o_frames(s_fr1));
  // Shared data line: unselected slave shows a stale-inverse level
  assign i_serial_data_in = o_master_select_out_b[0] ? s_miso1 : s_miso0;
  // System and unrelated link clocks
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial
  begin
    i_link_clk = 1'b0;
    #3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  // Hang guard, well above the few thousand cycles needed
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++)
      rev[i] = v[31-i];
  endfunction
  function automatic logic [31:0] wd(input int id, input int k);
    wd = {8'hc3, id[7:0], 8'h96, k[7:0]};
  endfunction
  // Wait for one channel's frame end pulse, bounded
  task automatic wait_fe(input logic ch);
    for (t = 0; t < 4000 && o_frame_end_irq[ch] !== 1'b1; t++)
      @(negedge i_clk);
  endtask
  // Drain receive words, follow the echo chain, then an empty read
  task automatic drain(input row_t r, input int id, input int base);
    logic v;
    logic [31:0] d;
    chk("frames", r.n, (r.ch ? s_fr1 : s_fr0) - base);
    for (int k = 0; k <= r.n; k++)
    begin
      v = 1'b0;
      {i_rx_rd, i_rx_ch} = {1'b1, r.ch};
      @(negedge i_clk);
      i_rx_rd = 1'b0;
      repeat (2)
      begin
        if (o_rx_valid === 1'b1)
        begin
          v = 1'b1;
          d = o_rx_data;
        end
        @(negedge i_clk);
      end
      chk("valid", r.rx && k < r.n, v);
      if (v && k < r.n)
        chk("rx word", r.lsb ? rev(prev[r.ch]) : prev[r.ch], d);
      if (k < r.n)
        prev[r.ch] = r.tx ? (r.lsb ? rev(wd(id, k)) : wd(id, k)) : '0;
    end
    chk("slave word", prev[r.ch], r.ch ? s_rx1 : s_rx0);
  endtask
  initial
  begin
    {i_tx_wr, i_rx_rd, i_tx_ch, i_rx_ch, i_ext_irq_pin_zero} = '0;
    {i_flag_clr_tx, i_flag_clr_rx, i_flag_clr_fe, i_lsb_first} = '0;
    {i_tx_enable, i_rx_enable, i_hw_trigger_select} = '0;
    i_tx_data = '0;
    i_clock_phase = 2'b11;
    i_channel_priority = {3'h0, 3'h7};
    i_frame_length = {6'h20, 6'h20};
    i_frame_count = '0;
    i_ram_start_offset = {16'h0040, 16'h0000};
    i_rst_b = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("select idle", 2'b11, o_master_select_out_b);
    chk("idle state", '0,
      {o_serial_shift_clock, o_channel_active, o_irq_flag_fe});
    i_rst_b = 1'b1;
    // Software-started transfers fed from transmit events
    foreach (rows[i])
    begin
      i_tx_enable[rows[i].ch] = rows[i].tx;
      i_rx_enable[rows[i].ch] = rows[i].rx;
      i_lsb_first[rows[i].ch] = rows[i].lsb;
      i_frame_count[rows[i].ch] = rows[i].n[7:0];
      f0 = rows[i].ch ? s_fr1 : s_fr0;
      @(negedge i_clk);
      {i_tx_wr, i_tx_ch, i_tx_data} = {1'b1, rows[i].ch, wd(i, 0)};
      begin
        int w, txp;
        w = 1;
        txp = 0;
        for (t = 0; t < 4000 && o_frame_end_irq[rows[i].ch] !== 1'b1; t++)
        begin
          @(negedge i_clk);
          i_tx_wr = o_tx_request_irq[rows[i].ch] && w < rows[i].n;
          i_tx_data = wd(i, w);
          txp += o_tx_request_irq[rows[i].ch];
          w += i_tx_wr;
        end
        chk("tx events", rows[i].ntx, txp);
      end
      chk("fe flag", 1, o_irq_flag_fe[rows[i].ch]);
      chk("rx flag", rows[i].rx, o_irq_flag_rx[rows[i].ch]);
      chk("idle after", 0, o_channel_active[rows[i].ch]);
      drain(rows[i], i, f0);
      {i_flag_clr_tx, i_flag_clr_rx, i_flag_clr_fe} = '1;
      @(negedge i_clk);
      {i_flag_clr_tx, i_flag_clr_rx, i_flag_clr_fe} = '0;
      chk("flags clear", '0,
        {o_irq_flag_tx, o_irq_flag_rx, o_irq_flag_fe});
    end
    // Pin-started top channel cuts into a preloaded 8-frame run
    {i_tx_enable, i_rx_enable, i_lsb_first} = {2'b11, 2'b11, 2'b00};
    i_hw_trigger_select = 2'b10;
    i_frame_count = {8'd3, 8'd8};
    f0 = s_fr0;
    f1 = s_fr1;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge i_clk);
      i_tx_wr = 1'b1;
      i_tx_ch = k < 3 ? 1'b1 : 1'b0;
      i_tx_data = k < 3 ? wd(9, k) : wd(8, k - 3);
    end
    @(negedge i_clk);
    i_tx_wr = 1'b0;
    chk("pin channel waits", 0, o_channel_active[1]);
    while (s_fr0 - f0 < 2 && cyc < 20000)
      @(negedge i_clk);
    i_ext_irq_pin_zero = 1'b1;
    wait_fe(1'b1);
    chk("low still active", 1, o_channel_active[0]);
    chk("cut in", 1, s_fr0 - f0 < 8);
    i_ext_irq_pin_zero = 1'b0;
    wait_fe(1'b0);
    drain('{0, 8, 1, 1, 0, 0}, 8, f0);
    drain('{1, 3, 1, 1, 0, 0}, 9, f1);
    end_sim();
  end
endmodule // test_multichannel_spi_priority_preempt
